// *** hdl/card_host_ctrl_regs.sv ***
// Purpose: control registers of a memory card host: interrupt clear, card clock, configuration
// Assumes: AHB-Lite slave with zero wait states; event inputs come from same-clock logic
// Notes: raw status and mask registers are held here so the interrupt output can be formed
`timescale 1ns/1ns
`include "card_host_params.svh"
module card_host_ctrl_regs (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // interrupt sources from the command and data paths
    input wire logic [`NUM_SRC-1:0] event_i,
    // one byte moved on the card link
    input wire logic byte_strobe_i,
    // card side and fifo side controls
    output logic card_clk_o,
    output card_host_pkg::lane_mode_t lane_mode_o,
    output card_host_pkg::fifo_width_t tx_width_o,
    output card_host_pkg::fifo_width_t rx_width_o,
    output logic tx_flush_o,
    output logic rx_flush_o,
    output logic media_enable_o,
    output logic [3:0] block_size_o,
    output logic block_done_o,
    output logic irq_o
);
    import card_host_pkg::*;

    card_clk_if ck ();

    // bus state
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic ready_q;

    // register contents
    logic [`NUM_SRC-1:0] raw_q;
    logic [`NUM_SRC-1:0] raw_d;
    logic [`NUM_SRC-1:0] mask_q;
    logic gate_q;
    logic [3:0] delay_q;
    logic [15:0] divider_q;
    lane_mode_t lane_q;
    fifo_width_t txw_q;
    fifo_width_t rxw_q;
    logic enable_q;
    logic [3:0] bsize_q;

    // side effects
    logic tx_flush_q;
    logic rx_flush_q;
    logic irq_q;
    logic [15:0] byte_cnt_q;
    logic block_done_q;

    // decode
    logic addr_phase;
    logic rd_take;
    logic wr_now;
    logic wr_mask;
    logic wr_clear;
    logic wr_clk;
    logic wr_cfg;
    logic [7:0] rd_off;
    logic [31:0] clk_word;
    logic [31:0] cfg_word;
    logic [31:0] rd_mux;
    logic [`NUM_SRC-1:0] clr_vec;
    logic [1:0] new_txw;
    logic [1:0] new_rxw;
    logic [1:0] new_lane;
    logic new_enable;
    logic [3:0] new_bsize;
    logic new_gate;
    logic [3:0] new_delay;
    logic [15:0] new_divider;
    logic sel_raw;
    logic sel_mask;
    logic sel_clk;
    logic sel_cfg;
    logic [16:0] blk_len;
    logic [16:0] cnt_next;
    logic blk_valid;
    logic blk_end;

    // address phase is taken only when the slave is selected and the bus is ready
    assign addr_phase = hsel_i & hready_i & htrans_i[1];
    assign rd_take = addr_phase & ~hwrite_i;
    assign rd_off = haddr_i[7:0];
    assign wr_now = wr_pend_q;
    assign wr_mask = wr_now & (wr_addr_q == `OFF_IRQ_MASK);
    assign wr_clear = wr_now & (wr_addr_q == `OFF_IRQ_CLEAR);
    assign wr_clk = wr_now & (wr_addr_q == `OFF_CLK_CTRL);
    assign wr_cfg = wr_now & (wr_addr_q == `OFF_IF_CONFIG);

    // readback words, reserved bits read zero
    assign clk_word = {gate_q, 11'h000, delay_q, divider_q};
    assign cfg_word = {18'h00000, lane_q, 2'h0, txw_q, rxw_q, enable_q, 1'b0, bsize_q};

    // read offset selects
    assign sel_raw = (rd_off == `OFF_RAW_STATUS);
    assign sel_mask = (rd_off == `OFF_IRQ_MASK);
    assign sel_clk = (rd_off == `OFF_CLK_CTRL);
    assign sel_cfg = (rd_off == `OFF_IF_CONFIG);

    // read selection; clear register is write-only and reads zero
    assign rd_mux = sel_raw ? {13'h0000, raw_q} :
                    sel_mask ? {13'h0000, mask_q} :
                    sel_clk ? clk_word :
                    sel_cfg ? cfg_word :
                    32'h00000000;

    // bus address capture, write lands in the data phase
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            ready_q <= 1'b0;
        end else begin
            wr_pend_q <= addr_phase & hwrite_i;
            wr_addr_q <= haddr_i[7:0];
            ready_q <= 1'b1;
        end
    end

    // read data registered at the address phase, stands through the data phase
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h00000000;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    // write-one-to-clear vector for the clearable sources
    assign clr_vec = wr_clear ? {1'b0, hwdata_i[`NUM_CLR_SRC-1:0]} : '0;

    // raw sources: a new event wins over a clear in the same cycle
    generate
        for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
            if (i == `SRC_LEVEL_BIT) begin : g_level
                assign raw_d[i] = event_i[i];
            end else begin : g_sticky
                assign raw_d[i] = event_i[i] | (raw_q[i] & ~clr_vec[i]);
            end
        end
    endgenerate

    // raw status, updated every cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            raw_q <= '0;
        end else begin
            raw_q <= raw_d;
        end
    end

    // interrupt mask, one suppresses a source
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_q <= `MASK_RST;
        end else if (wr_mask) begin
            mask_q <= hwdata_i[`NUM_SRC-1:0];
        end
    end

    // interrupt output, registered
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(raw_q & ~mask_q);
        end
    end

    // new clock control fields offered by a write
    assign new_gate = hwdata_i[`CLK_GATE_BIT];
    assign new_delay = hwdata_i[`CLK_DLY_MSB:`CLK_DLY_LSB];
    assign new_divider = hwdata_i[`CLK_DIV_MSB:`CLK_DIV_LSB];

    // clock control register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_q <= `CLK_GATE_RST;
            delay_q <= `CLK_DLY_RST;
            divider_q <= `CLK_DIV_RST;
        end else if (wr_clk) begin
            gate_q <= new_gate;
            delay_q <= new_delay;
            divider_q <= new_divider;
        end
    end

    // new configuration fields offered by a write
    assign new_lane = hwdata_i[`CFG_LANE_MSB:`CFG_LANE_LSB];
    assign new_txw = hwdata_i[`CFG_TXW_MSB:`CFG_TXW_LSB];
    assign new_rxw = hwdata_i[`CFG_RXW_MSB:`CFG_RXW_LSB];
    assign new_enable = hwdata_i[`CFG_EN_BIT];
    assign new_bsize = hwdata_i[`CFG_BS_MSB:`CFG_BS_LSB];

    // configuration register: lanes, enable, block size
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lane_q <= LANES_1;
            enable_q <= 1'b0;
            bsize_q <= `CFG_BS_RESERVED;
        end else if (wr_cfg) begin
            lane_q <= lane_mode_t'(new_lane);
            enable_q <= new_enable;
            bsize_q <= new_bsize;
        end
    end

    // configuration register: fifo access widths
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            txw_q <= FIFO_W8;
            rxw_q <= FIFO_W8;
        end else if (wr_cfg) begin
            txw_q <= fifo_width_t'(new_txw);
            rxw_q <= fifo_width_t'(new_rxw);
        end
    end

    // one-cycle flush when a width field actually changes
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_flush_q <= 1'b0;
            rx_flush_q <= 1'b0;
        end else begin
            tx_flush_q <= wr_cfg & (new_txw != txw_q);
            rx_flush_q <= wr_cfg & (new_rxw != rxw_q);
        end
    end

    // block length is two to the field value bytes; zero is reserved and counts nothing
    assign blk_valid = (bsize_q != `CFG_BS_RESERVED) & enable_q;
    assign blk_len = 17'h00001 << bsize_q;
    assign cnt_next = {1'b0, byte_cnt_q} + 17'h00001;
    assign blk_end = blk_valid & byte_strobe_i & (cnt_next == blk_len);

    // byte counter splitting a transfer into block-length chunks
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            byte_cnt_q <= 16'h0000;
            block_done_q <= 1'b0;
        end else begin
            block_done_q <= blk_end;
            if (!blk_valid || blk_end) begin
                byte_cnt_q <= 16'h0000;
            end else if (byte_strobe_i) begin
                byte_cnt_q <= cnt_next[15:0];
            end
        end
    end

    // clock generator settings; divider validity is checked in the generator, which holds the clock low below 2
    assign ck.gate = gate_q;
    assign ck.divider = divider_q;
    assign ck.delay = delay_q;

    card_clk_gen u_clk_gen (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .ck(ck.gen)
    );

    // outputs, each from a flop except hresp_o, which is a constant
    assign hrdata_o = rdata_q;
    assign hreadyout_o = ready_q;
    assign hresp_o = 1'b0; // constant okay response
    assign card_clk_o = ck.card_clk;
    assign lane_mode_o = lane_q;
    assign tx_width_o = txw_q;
    assign rx_width_o = rxw_q;
    assign tx_flush_o = tx_flush_q;
    assign rx_flush_o = rx_flush_q;
    assign media_enable_o = enable_q;
    assign block_size_o = bsize_q;
    assign block_done_o = block_done_q;
    assign irq_o = irq_q;

endmodule : card_host_ctrl_regs

// *** hdl/card_host_params.svh ***
// Purpose: named offsets, field positions and reset values of the card host control registers
// Assumes: included by bare name from modules; the package does not include it
// Notes: definitions only
`ifndef CARD_HOST_PARAMS_SVH
`define CARD_HOST_PARAMS_SVH

// register byte offsets
`define OFF_RAW_STATUS 8'h00
`define OFF_IRQ_MASK 8'h04
`define OFF_IRQ_CLEAR 8'h08
`define OFF_CLK_CTRL 8'h0C
`define OFF_IF_CONFIG 8'h10

// interrupt sources
`define NUM_SRC 19
`define NUM_CLR_SRC 18
`define SRC_LEVEL_BIT 18
`define MASK_RST 19'h7FFFF

// clock control fields
`define CLK_GATE_BIT 31
`define CLK_DLY_MSB 19
`define CLK_DLY_LSB 16
`define CLK_DIV_MSB 15
`define CLK_DIV_LSB 0
`define CLK_CTRL_RST 32'h80000000
`define CLK_GATE_RST 1'b1
`define CLK_DIV_RST 16'h0000
`define CLK_DLY_RST 4'h0
`define CLK_DIV_MIN 16'h0002
`define CLK_DLY_TAPS 16

// configuration fields
`define CFG_LANE_MSB 13
`define CFG_LANE_LSB 12
`define CFG_TXW_MSB 9
`define CFG_TXW_LSB 8
`define CFG_RXW_MSB 7
`define CFG_RXW_LSB 6
`define CFG_EN_BIT 5
`define CFG_BS_MSB 3
`define CFG_BS_LSB 0
`define CFG_BS_RESERVED 4'h0

`endif

// *** hdl/card_host_pkg.sv ***
// Purpose: shared types of the card host control block
// Assumes: field codes as held in the configuration register
// Notes: constants live in card_host_params.svh
package card_host_pkg;

    // external data lane count, code 11 reserved
    typedef enum logic [1:0] {
        LANES_1,
        LANES_4,
        LANES_8,
        LANES_RSVD
    } lane_mode_t;

    // fifo access width on the internal side
    typedef enum logic [1:0] {
        FIFO_W8,
        FIFO_W16,
        FIFO_W32,
        FIFO_W64
    } fifo_width_t;

endpackage : card_host_pkg

// *** hdl/card_clk_if.sv ***
// Purpose: carries card clock settings from the register bank to the clock generator
// Assumes: single clock domain
// Notes: card_clk is the generator's registered output
`timescale 1ns/1ns
interface card_clk_if;
    logic gate;
    logic [15:0] divider;
    logic [3:0] delay;
    logic card_clk;

    modport ctrl (output gate, output divider, output delay, input card_clk);
    modport gen (input gate, input divider, input delay, output card_clk);
endinterface : card_clk_if

// *** hdl/card_clk_gen.sv ***
// Purpose: divides the system clock into the card serial clock, delays and gates it
// Assumes: divider of 2 or more; smaller values hold the clock low
// Notes: gate forces the output low, restarts the divider and empties the delay line
`timescale 1ns/1ns
`include "card_host_params.svh"
module card_clk_gen (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    card_clk_if.gen ck
);
    import card_host_pkg::*;

    logic [15:0] div_cnt_q;
    logic [15:0] div_cnt_d;
    logic div_clk_q;
    logic [`CLK_DLY_TAPS-1:0] taps_q;
    logic out_q;
    logic div_ok;
    logic last_cnt;
    logic [15:0] half;

    // a period is divider cycles, high for the first half of it
    assign div_ok = (ck.divider >= `CLK_DIV_MIN);
    assign last_cnt = (div_cnt_q >= (ck.divider - 16'h0001));
    assign div_cnt_d = last_cnt ? 16'h0000 : div_cnt_q + 16'h0001;
    assign half = {1'b0, ck.divider[15:1]};

    // divider counter, restarted while gated or invalid
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_q <= 16'h0000;
            div_clk_q <= 1'b0;
        end else if (ck.gate || !div_ok) begin
            div_cnt_q <= 16'h0000;
            div_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            div_clk_q <= (div_cnt_d < half);
        end
    end

    // delay line, one system cycle per step; emptied while gated so no stale pulse leaks out
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            taps_q <= '0;
        end else if (ck.gate) begin
            taps_q <= '0;
        end else begin
            taps_q <= {taps_q[`CLK_DLY_TAPS-2:0], div_clk_q};
        end
    end

    // output flop, held low while gated
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= ck.gate ? 1'b0 : taps_q[ck.delay];
        end
    end

    assign ck.card_clk = out_q;

endmodule : card_clk_gen

// *** verification/card_host_ctrl_checker.sv ***
// Purpose: port-level assertions for the card host control registers
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into every instance of the register block
`timescale 1ns/1ns
`include "card_host_params.svh"
module card_host_ctrl_checker (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic byte_strobe_i,
    input wire card_host_pkg::lane_mode_t lane_mode_o,
    input wire card_host_pkg::fifo_width_t tx_width_o,
    input wire card_host_pkg::fifo_width_t rx_width_o,
    input wire logic tx_flush_o,
    input wire logic rx_flush_o,
    input wire logic media_enable_o,
    input wire logic [3:0] block_size_o,
    input wire logic block_done_o
);
    import card_host_pkg::*;
    logic cfg_wr;
    // configuration write taken in an address phase
    assign cfg_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i
        && haddr_i[7:0] == `OFF_IF_CONFIG;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    AST_OKAY: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    AST_READY: assert property ($past(arst_n_i) |-> hreadyout_o == 1'b1)
        else $error("slave not ready after reset");
    AST_CFG_WRITE: assert property ($changed({lane_mode_o, tx_width_o, rx_width_o,
        media_enable_o, block_size_o}) |-> $past(cfg_wr, 2))
        else $error("config outputs changed without a config write");
    AST_TX_FLUSH: assert property ($changed(tx_width_o) |-> tx_flush_o)
        else $error("tx width change without flush");
    AST_RX_FLUSH: assert property ($changed(rx_width_o) |-> rx_flush_o)
        else $error("rx width change without flush");
    AST_DONE_CAUSE: assert property (block_done_o |-> $past(byte_strobe_i))
        else $error("block done without a byte before it");
    AST_DONE_PULSE: assert property (block_done_o |=> !block_done_o)
        else $error("block done longer than one cycle");
    AST_DONE_EN: assert property (block_done_o |-> media_enable_o && block_size_o != 4'h0)
        else $error("block done while idle or size reserved");
endmodule : card_host_ctrl_checker
bind card_host_ctrl_regs card_host_ctrl_checker chk (.clk_sys_i, .arst_n_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .byte_strobe_i,
    .lane_mode_o, .tx_width_o, .rx_width_o, .tx_flush_o, .rx_flush_o, .media_enable_o,
    .block_size_o, .block_done_o);

// *** verification/card_partner.sv ***
// Purpose: card side of the link, moves one byte per eight card clocks
// Assumes: card clock sampled in the system clock domain
// Notes: bytes flow only while the media interface is enabled
`timescale 1ns/1ns
module card_partner (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic card_clk_i,
    input wire logic enable_i,
    output logic byte_strobe_o
);
    logic clk_q;
    logic [2:0] bit_q;
    // count card clock rises, strobe on every eighth bit
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_q <= 1'b0;
            bit_q <= 3'h0;
            byte_strobe_o <= 1'b0;
        end else begin
            clk_q <= card_clk_i;
            byte_strobe_o <= 1'b0;
            if (enable_i && card_clk_i && !clk_q) begin
                bit_q <= bit_q + 3'h1;
                byte_strobe_o <= (bit_q == 3'h7);
            end
        end
    end
endmodule : card_partner

// *** verification/card_host_ctrl_regs_bench.sv ***
// Purpose: self-checking bench of the card host control registers
// Assumes: zero-wait AHB-Lite slave, card partner paces bytes
// Notes: a register model in the bench gives the register expectations; clock, level and block checks use fixed values
`timescale 1ns/1ns
`include "card_host_params.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module card_host_ctrl_regs_bench;
    import card_host_pkg::*;
    logic clk_sys_i = 0, arst_n_i = 0, hsel = 0, hwrite = 0;
    logic hready, hresp, card_clk, tx_fl, rx_fl, men, done, irq, strobe;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [31:0] m_clk, m_cfg, m_mask, m_raw;
    logic [1:0] htrans = 0;
    logic [18:0] ev = 0;
    logic [3:0] bsz;
    lane_mode_t lane;
    fifo_width_t txw, rxw;
    int bad_count = 0, compares = 0, seed = 80, n, n0;
    card_host_ctrl_regs dut (.clk_sys_i, .arst_n_i, .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .event_i(ev), .byte_strobe_i(strobe), .card_clk_o(card_clk), .lane_mode_o(lane),
        .tx_width_o(txw), .rx_width_o(rxw), .tx_flush_o(tx_fl), .rx_flush_o(rx_fl),
        .media_enable_o(men), .block_size_o(bsz), .block_done_o(done), .irq_o(irq));
    card_partner card (.clk_sys_i, .arst_n_i, .card_clk_i(card_clk), .enable_i(men),
        .byte_strobe_o(strobe));
    // system clock
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // hang guard
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        bad_count++;
        test_done();
    end
    task automatic reset_all();
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        m_clk = `CLK_CTRL_RST;
        m_cfg = 32'h0;
        m_mask = `MASK_RST;
        m_raw = 32'h0;
        repeat (2) @(posedge clk_sys_i);
    endtask : reset_all
    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        case (a)
            `OFF_IRQ_MASK: m_mask = d & 32'h7FFFF;
            `OFF_IRQ_CLEAR: m_raw = m_raw & ~d;
            `OFF_CLK_CTRL: m_clk = d & 32'h800FFFFF;
            `OFF_IF_CONFIG: begin
                @(negedge clk_sys_i);
                `CHK("tx flush", m_cfg[9:8] != d[9:8], tx_fl)
                `CHK("rx flush", m_cfg[7:6] != d[7:6], rx_fl)
                m_cfg = d & 32'h33EF;
            end
            default: ;
        endcase
    endtask : wr
    task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(s, e, rd)
    endtask : rdchk
    task automatic pulse(input logic [31:0] d);
        @(posedge clk_sys_i);
        ev <= d[18:0];
        @(posedge clk_sys_i);
        ev <= '0;
        m_raw = m_raw | d;
    endtask : pulse
    task automatic irqchk();
        rdchk("raw status", `OFF_RAW_STATUS, m_raw);
        `CHK("irq", |(m_raw & ~m_mask), irq)
    endtask : irqchk
    task automatic low_chk();
        repeat (3) @(posedge clk_sys_i);
        repeat (20) begin
            @(negedge clk_sys_i);
            `CHK("card clk low", 1'b0, card_clk)
        end
    endtask : low_chk
    // cycles from an ungating write to the first card clock rise
    task automatic first_rise(output int t);
        t = 0;
        do begin
            @(negedge clk_sys_i);
            t++;
        end while (card_clk !== 1'b1 && t < 100);
    endtask : first_rise
    // cycles between two rises of the card clock
    task automatic period(output int p);
        logic prev;
        prev = 1'b1;
        p = -1;
        repeat (200) begin
            @(negedge clk_sys_i);
            if (p >= 0) p++;
            if (card_clk === 1'b1 && prev === 1'b0) begin
                if (p > 0) break;
                p = 0;
            end
            prev = card_clk;
        end
    endtask : period
    // bytes between two block done pulses
    task automatic count_block(output int c);
        c = 0;
        repeat (2000) begin
            @(negedge clk_sys_i);
            if (done === 1'b1) break;
        end
        repeat (2000) begin
            @(negedge clk_sys_i);
            if (done === 1'b1) break;
            if (strobe === 1'b1) c++;
        end
    endtask : count_block
    // main sequence
    initial begin
        reset_all();
        rdchk("clock ctrl", `OFF_CLK_CTRL, `CLK_CTRL_RST);
        rdchk("config", `OFF_IF_CONFIG, 32'h0);
        rdchk("mask", `OFF_IRQ_MASK, `MASK_RST);
        rdchk("clear reads", `OFF_IRQ_CLEAR, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        low_chk();
        repeat (8) begin
            wr(`OFF_IF_CONFIG, $random(seed) & 32'h33EF);
            rdchk("config", `OFF_IF_CONFIG, m_cfg);
            `CHK("lanes", m_cfg[13:12], lane)
            `CHK("tx width", m_cfg[9:8], txw)
            `CHK("rx width", m_cfg[7:6], rxw)
            `CHK("enable", m_cfg[5], men)
            `CHK("block size", m_cfg[3:0], bsz)
        end
        wr(`OFF_IF_CONFIG, 32'h0);
        wr(`OFF_CLK_CTRL, 32'h80000004);
        wr(`OFF_CLK_CTRL, 32'h00000004);
        first_rise(n0);
        wr(`OFF_CLK_CTRL, 32'h80030004);
        low_chk();
        wr(`OFF_CLK_CTRL, 32'h00030004);
        first_rise(n);
        `CHK("clock delay steps", 3, n - n0)
        rdchk("clock ctrl", `OFF_CLK_CTRL, m_clk);
        period(n);
        `CHK("card clk period", 4, n)
        wr(`OFF_CLK_CTRL, 32'h80030004);
        low_chk();
        wr(`OFF_CLK_CTRL, 32'h80000002);
        wr(`OFF_CLK_CTRL, 32'h00000002);
        period(n);
        `CHK("card clk period", 2, n)
        wr(`OFF_IRQ_MASK, 32'h0);
        pulse(32'h3FFFF);
        irqchk();
        for (int i = 0; i < 18; i++) begin
            wr(`OFF_IRQ_CLEAR, 32'h1 << i);
            irqchk();
        end
        wr(`OFF_IRQ_MASK, 32'h7FFFF);
        pulse($random(seed) & 32'h3FFFF);
        irqchk();
        wr(`OFF_IRQ_MASK, 32'h0);
        irqchk();
        wr(`OFF_IRQ_CLEAR, 32'h3FFFF);
        irqchk();
        @(posedge clk_sys_i);
        ev <= 19'h40000;
        rdchk("level source", `OFF_RAW_STATUS, 32'h40000);
        `CHK("irq level", 1'b1, irq)
        ev <= '0;
        rdchk("level source", `OFF_RAW_STATUS, 32'h0);
        `CHK("irq level", 1'b0, irq)
        wr(`OFF_IF_CONFIG, 32'h22);
        count_block(n);
        `CHK("bytes per block", 4, n)
        reset_all();
        rdchk("clock ctrl", `OFF_CLK_CTRL, `CLK_CTRL_RST);
        rdchk("config", `OFF_IF_CONFIG, 32'h0);
        rdchk("mask", `OFF_IRQ_MASK, `MASK_RST);
        `CHK("irq", 1'b0, irq)
        low_chk();
        test_done();
    end
endmodule : card_host_ctrl_regs_bench
